/* phy_status_summary.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_status_summary (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        reg_read_in,
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic        crossover_auto_enable_in,
   input  wire logic        crossover_force_in,
   input  wire logic        crossover_swapped_in,
   input  wire logic        rx_error_event_in,
   input  wire logic        false_carrier_event_in,
   input  wire logic        polarity_inverted_in,
   input  wire logic        signal_detect_in,
   input  wire logic        descrambler_lock_in,
   input  wire logic        page_received_event_in,
   input  wire logic        remote_fault_event_in,
   input  wire logic        jabber_status_in,
   input  wire logic        autoneg_complete_in,
   input  wire logic        loopback_enable_in,
   input  wire logic        full_duplex_in,
   input  wire logic        speed_10_in,
   input  wire logic        link_status_in,
   output logic      [15:0] read_data_out,
   output logic             read_valid_out
);
   import phy_status_pkg::*;

   // ==================================================
   // pin synchronisers (all status sources are asynchronous to the clock)
   localparam int N_SYNC = 15;
   logic [N_SYNC-1:0] raw;
   logic [N_SYNC-1:0] sync_a;
   logic [N_SYNC-1:0] sync_b;
   assign raw = {crossover_auto_enable_in, crossover_force_in, crossover_swapped_in,
                 rx_error_event_in, false_carrier_event_in, polarity_inverted_in,
                 signal_detect_in, descrambler_lock_in, page_received_event_in,
                 remote_fault_event_in, jabber_status_in, autoneg_complete_in,
                 loopback_enable_in, full_duplex_in, speed_10_in};
   logic link_a;
   logic link_s;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync_a <= '0;
         sync_b <= '0;
         link_a <= 1'b0;
         link_s <= 1'b0;
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
         link_a <= link_status_in;
         link_s <= link_a;
      end
   end

   logic x_en, x_force, x_swap, rx_err, f_carr, pol, sig_det, d_lock;
   logic page_ev, rfault_ev, jabber, an_done, loopback, duplex, spd10;
   assign {x_en, x_force, x_swap, rx_err, f_carr, pol, sig_det, d_lock,
           page_ev, rfault_ev, jabber, an_done, loopback, duplex, spd10} = sync_b;

   // ==================================================
   // read strobes by address
   function automatic logic read_of(input logic rd, input logic [4:0] a,
                                    input logic [4:0] target);
      read_of = rd && (a == target);
   endfunction : read_of

   logic rd_self, rd_rxerr, rd_fcarr, rd_ten, rd_autoneg_expansion_reg, rd_basic_mode_status_reg;
   assign rd_self  = read_of(reg_read_in, reg_addr_in, ADDR_STATUS_SUMMARY);
   assign rd_rxerr = read_of(reg_read_in, reg_addr_in, ADDR_RX_ERROR);
   assign rd_fcarr = read_of(reg_read_in, reg_addr_in, ADDR_FALSE_CARRIER);
   assign rd_ten   = read_of(reg_read_in, reg_addr_in, ADDR_TEN_STATUS);
   assign rd_autoneg_expansion_reg  = read_of(reg_read_in, reg_addr_in, ADDR_AN_EXPANSION);
   assign rd_basic_mode_status_reg  = read_of(reg_read_in, reg_addr_in, ADDR_BASIC_STATUS);

   // ==================================================
   // latched-high flags, each cleared by its owning register read
   sticky_if rx_err_if ();
   sticky_if fcarr_if ();
   sticky_if pol_if ();
   sticky_if page_if ();
   sticky_if rfault_if ();

   assign rx_err_if.set_strobe   = rx_err;
   assign rx_err_if.clear_strobe = rd_rxerr;
   assign fcarr_if.set_strobe    = f_carr;
   assign fcarr_if.clear_strobe  = rd_fcarr;
   assign pol_if.set_strobe      = pol;
   assign pol_if.clear_strobe    = rd_ten;
   assign page_if.set_strobe     = page_ev;
   assign page_if.clear_strobe   = rd_autoneg_expansion_reg;
   assign rfault_if.set_strobe   = rfault_ev;
   assign rfault_if.clear_strobe = rd_basic_mode_status_reg;

   sticky_flag u_rx_err (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .port_if(rx_err_if));
   sticky_flag u_fcarr  (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .port_if(fcarr_if));
   sticky_flag u_pol    (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .port_if(pol_if));
   sticky_flag u_page   (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .port_if(page_if));
   sticky_flag u_rfault (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .port_if(rfault_if));

   // ==================================================
   // latch-low bits: once low, held low until this register is read
   logic sig_det_held;
   logic d_lock_held;
   logic sig_det_low;
   logic d_lock_low;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sig_det_low <= 1'b0;
         d_lock_low  <= 1'b0;
      end else begin
         // a fall in the read cycle itself stays caught
         sig_det_low <= !sig_det || (sig_det_low && !rd_self);
         d_lock_low  <= !d_lock  || (d_lock_low  && !rd_self);
      end
   end
   assign sig_det_held = sig_det && !sig_det_low;
   assign d_lock_held  = d_lock  && !d_lock_low;

   // ==================================================
   // crossover state: live only while auto enabled and not forced
   logic crossover;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         crossover <= 1'b0;
      end else if (x_force) begin
         crossover <= 1'b1;
      end else if (x_en) begin
         crossover <= x_swap;
      end else begin
         crossover <= 1'b0;
      end
   end

   // ==================================================
   // assembled word and read port
   logic [15:0] status_word;
   always_comb begin
      status_word                 = STATUS_RESET;
      status_word[BIT_RSVD_HI]    = 1'b0;
      status_word[BIT_RSVD_LO]    = 1'b0;
      status_word[BIT_CROSSOVER]  = crossover;
      status_word[BIT_RX_ERR]     = rx_err_if.flag;
      status_word[BIT_POLARITY]   = pol_if.flag;
      status_word[BIT_FALSE_CARR] = fcarr_if.flag;
      status_word[BIT_SIG_DETECT] = sig_det_held;
      status_word[BIT_DESCR_LOCK] = d_lock_held;
      status_word[BIT_PAGE_RX]    = page_if.flag;
      status_word[BIT_REMOTE_FLT] = rfault_if.flag;
      status_word[BIT_JABBER]     = jabber;
      status_word[BIT_AN_DONE]    = an_done;
      status_word[BIT_LOOPBACK]   = loopback;
      status_word[BIT_DUPLEX]     = duplex;
      status_word[BIT_SPEED10]    = spd10;
      status_word[BIT_LINK]       = link_s;
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         read_data_out  <= STATUS_RESET;
         read_valid_out <= 1'b0;
      end else begin
         read_valid_out <= rd_self;
         read_data_out  <= rd_self ? status_word : STATUS_RESET;
      end
   end

   // ==================================================
   // checks
   property p_reserved_zero;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      read_valid_out |-> (!read_data_out[BIT_RSVD_HI] && !read_data_out[BIT_RSVD_LO]);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit read as one");

   property p_rx_err_sticky;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (rx_err_if.flag && !rd_rxerr) |=> rx_err_if.flag;
   endproperty
   a_rx_err_sticky: assert property (p_rx_err_sticky)
      else $error("receive error latch dropped without its read");

   property p_rx_err_set;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      rx_err |=> rx_err_if.flag;
   endproperty
   a_rx_err_set: assert property (p_rx_err_set)
      else $error("receive error event not latched");

   property p_fcarr_clear;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (rd_fcarr && !f_carr) |=> !fcarr_if.flag;
   endproperty
   a_fcarr_clear: assert property (p_fcarr_clear)
      else $error("false carrier latch not cleared by its read");

   property p_pol_not_self_cleared;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (pol_if.flag && rd_self) |=> pol_if.flag;
   endproperty
   a_pol_not_self_cleared: assert property (p_pol_not_self_cleared)
      else $error("polarity flag cleared by own read");

   property p_sig_low_held;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (!sig_det && !rd_self) ##1 !rd_self |=> !sig_det_held;
   endproperty
   a_sig_low_held: assert property (p_sig_low_held)
      else $error("signal detect low not held");

   property p_lock_low_held;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      !d_lock |=> !d_lock_held;
   endproperty
   a_lock_low_held: assert property (p_lock_low_held)
      else $error("descrambler lock low not held");

   property p_page_set;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (page_ev && !rd_autoneg_expansion_reg) |=> page_if.flag [*1] ##0 (rd_autoneg_expansion_reg || page_if.flag);
   endproperty
   a_page_set: assert property (p_page_set)
      else $error("page received not latched");

   property p_rfault_clear;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (rd_basic_mode_status_reg && !rfault_ev) |=> !rfault_if.flag;
   endproperty
   a_rfault_clear: assert property (p_rfault_clear)
      else $error("remote fault not cleared by basic status read");

   property p_read_link;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      rd_self |=> (read_valid_out && read_data_out[BIT_LINK] == $past(link_s));
   endproperty
   a_read_link: assert property (p_read_link)
      else $error("link bit not returned on read");

   property p_cross_auto;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (x_en && !x_force) |=> crossover == $past(x_swap);
   endproperty
   a_cross_auto: assert property (p_cross_auto)
      else $error("crossover not following live state");
endmodule : phy_status_summary
`default_nettype wire

/* phy_status_pkg.sv */
package phy_status_pkg;
   // ==================================================
   // register map
   localparam logic [4:0]  ADDR_STATUS_SUMMARY = 5'h10;
   localparam logic [4:0]  ADDR_AN_EXPANSION   = 5'h06;
   localparam logic [4:0]  ADDR_BASIC_STATUS   = 5'h01;
   localparam logic [4:0]  ADDR_FALSE_CARRIER  = 5'h14;
   localparam logic [4:0]  ADDR_RX_ERROR       = 5'h15;
   localparam logic [4:0]  ADDR_TEN_STATUS     = 5'h0a;
   localparam logic [15:0] STATUS_RESET        = 16'h0000;
   // ==================================================
   // field positions
   localparam int BIT_LINK        = 0;
   localparam int BIT_SPEED10     = 1;
   localparam int BIT_DUPLEX      = 2;
   localparam int BIT_LOOPBACK    = 3;
   localparam int BIT_AN_DONE     = 4;
   localparam int BIT_JABBER      = 5;
   localparam int BIT_REMOTE_FLT  = 6;
   localparam int BIT_RSVD_LO     = 7;
   localparam int BIT_PAGE_RX     = 8;
   localparam int BIT_DESCR_LOCK  = 9;
   localparam int BIT_SIG_DETECT  = 10;
   localparam int BIT_FALSE_CARR  = 11;
   localparam int BIT_POLARITY    = 12;
   localparam int BIT_RX_ERR      = 13;
   localparam int BIT_CROSSOVER   = 14;
   localparam int BIT_RSVD_HI     = 15;
endpackage : phy_status_pkg

/* sticky_if.sv */
`timescale 1ns/10ps
`default_nettype none
// set and clear strobes for the hardware-set, read-cleared flags
interface sticky_if;
   logic set_strobe;
   logic clear_strobe;
   logic flag;
   modport owner (input set_strobe, input clear_strobe, output flag);
   modport user  (output set_strobe, output clear_strobe, input flag);
endinterface : sticky_if
`default_nettype wire

/* sticky_flag.sv */
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
   input  wire logic ref_clk_in,
   input  wire logic reset_n_in,
   sticky_if.owner   port_if
);
   // ==================================================
   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_if.flag <= 1'b0;
      end else if (port_if.set_strobe) begin
         port_if.flag <= 1'b1;
      end else if (port_if.clear_strobe) begin
         port_if.flag <= 1'b0;
      end
   end
endmodule : sticky_flag
`default_nettype wire

/* mgmt_reader.sv */
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// station management side: one read per go pulse
module mgmt_reader #(
   parameter bit AUTONEG_ENABLED = 1'b1
) (
   input  wire logic        ref_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        go_in,
   input  wire logic [4:0]  addr_in,
   input  wire logic        read_valid_in,
   input  wire logic [15:0] read_data_in,
   output logic             reg_read_out,
   output logic      [4:0]  reg_addr_out,
   output logic             done_out,
   output logic      [15:0] data_out,
   output logic             link_trusted_out
);
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_read_out <= 1'b0;
         reg_addr_out <= 5'h1f;
      end else begin
         reg_read_out <= go_in;
         // released address shows a changing value, its inverse and then the last one again on alternate cycles
         reg_addr_out <= go_in ? addr_in : ~reg_addr_out;
      end
   end
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         done_out <= 1'b0;
         data_out <= 16'h0000;
      end else begin
         done_out <= read_valid_in;
         if (read_valid_in) begin
            data_out <= read_data_in;
         end
      end
   end
   // speed and duplex are only believed with a resolved link
   assign link_trusted_out = data_out[0] & (data_out[4] | !AUTONEG_ENABLED);
endmodule : mgmt_reader
`default_nettype wire

/* phy_status_summary_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_status_summary_tb;
   import phy_status_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        go = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic        reg_read;
   logic [4:0]  reg_addr;
   logic        done;
   logic [15:0] data;
   logic        trusted;
   logic [15:0] read_data;
   logic        read_valid;
   logic [2:0]  xo = 3'h0;
   logic [4:0]  evt = 5'h00;
   logic [5:0]  live = 6'h00;
   logic        sd = 1'b0;
   logic        dl = 1'b0;
   logic [15:0] d;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cycles = 0;
   logic [4:0]  clr_addr [5] = '{ADDR_RX_ERROR, ADDR_FALSE_CARRIER, ADDR_TEN_STATUS,
                                  ADDR_AN_EXPANSION, ADDR_BASIC_STATUS};
   int          clr_bit [5] = '{BIT_RX_ERR, BIT_FALSE_CARR, BIT_POLARITY, BIT_PAGE_RX,
                                BIT_REMOTE_FLT};
   // {expected, auto, force, swapped}
   logic [3:0]  xo_tab [6] = '{4'hb, 4'ha, 4'h4, 4'hd, 4'he, 4'h1};
   always #2.5 ref_clk = ~ref_clk;
   phy_status_summary uut (
      .ref_clk_in               (ref_clk),
      .reset_n_in               (reset_n),
      .reg_read_in              (reg_read),
      .reg_addr_in              (reg_addr),
      .crossover_auto_enable_in (xo[2]),
      .crossover_force_in       (xo[1]),
      .crossover_swapped_in     (xo[0]),
      .rx_error_event_in        (evt[0]),
      .false_carrier_event_in   (evt[1]),
      .polarity_inverted_in     (evt[2]),
      .signal_detect_in         (sd),
      .descrambler_lock_in      (dl),
      .page_received_event_in   (evt[3]),
      .remote_fault_event_in    (evt[4]),
      .jabber_status_in         (live[5]),
      .autoneg_complete_in      (live[4]),
      .loopback_enable_in       (live[3]),
      .full_duplex_in           (live[2]),
      .speed_10_in              (live[1]),
      .link_status_in           (live[0]),
      .read_data_out            (read_data),
      .read_valid_out           (read_valid)
   );
   mgmt_reader host (
      .ref_clk_in       (ref_clk),
      .reset_n_in       (reset_n),
      .go_in            (go),
      .addr_in          (addr),
      .read_valid_in    (read_valid),
      .read_data_in     (read_data),
      .reg_read_out     (reg_read),
      .reg_addr_out     (reg_addr),
      .done_out         (done),
      .data_out         (data),
      .link_trusted_out (trusted)
   );
   // ==================================================
   // tasks
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // inputs pass two flops, crossover and the latched flags three
   task automatic settle;
      repeat (4) @(posedge ref_clk);
   endtask : settle
   task automatic rd(input logic [4:0] a, output logic [15:0] v);
      bit seen;
      seen = 1'b0;
      @(posedge ref_clk);
      go <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      go <= 1'b0;
      if (a == ADDR_STATUS_SUMMARY) begin
         for (int n = 0; n < 8 && !seen; n++) begin
            @(posedge ref_clk);
            #1;
            seen = (done === 1'b1);
         end
         if (!seen) begin
            chk("read answer", 16'h0001, 16'h0000);
         end
      end else begin
         repeat (3) @(posedge ref_clk);
      end
      v = data;
   endtask : rd
   task automatic rc(input string what, input logic [15:0] exp);
      logic [15:0] v;
      rd(ADDR_STATUS_SUMMARY, v);
      chk(what, exp, v);
   endtask : rc
   // ==================================================
   // tests
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rc("reset word", STATUS_RESET);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         live <= 6'(1 << i);
         settle();
         rc("live bit", 16'(1 << i));
         rc("live bit reread", 16'(1 << i));
      end
      @(posedge ref_clk);
      live <= 6'h11;
      settle();
      rc("link word", 16'h0011);
      chk("trusted", 16'h0001, {15'h0000, trusted});
      @(posedge ref_clk);
      live <= 6'h00;
      $display("test live done");
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         xo <= xo_tab[i][2:0];
         settle();
         rc("crossover", {1'b0, xo_tab[i][3], 14'h0000});
      end
      @(posedge ref_clk);
      xo <= 3'h0;
      $display("test crossover done");
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         evt <= 5'(1 << i);
         @(posedge ref_clk);
         evt <= 5'h00;
         settle();
         rc("flag set", 16'(1 << clr_bit[i]));
         rd(clr_addr[(i + 1) % 5], d);
         rc("flag kept", 16'(1 << clr_bit[i]));
         rd(clr_addr[i], d);
         rc("flag cleared", 16'h0000);
      end
      $display("test flags done");
      @(posedge ref_clk);
      sd <= 1'b1;
      dl <= 1'b1;
      settle();
      rd(ADDR_STATUS_SUMMARY, d);
      rc("latch low follow", 16'h0600);
      @(posedge ref_clk);
      sd <= 1'b0;
      @(posedge ref_clk);
      sd <= 1'b1;
      settle();
      rc("latch low held", 16'h0200);
      rc("latch low released", 16'h0600);
      @(posedge ref_clk);
      dl <= 1'b0;
      @(posedge ref_clk);
      dl <= 1'b1;
      settle();
      rc("lock low held", 16'h0400);
      rc("lock low released", 16'h0600);
      $display("test latch low done");
      @(posedge ref_clk);
      xo <= 3'h2;
      evt <= 5'h1f;
      live <= 6'h3f;
      settle();
      rc("all set", 16'h7f7f);
      $display("test reserved done");
      conclude();
   end
endmodule : phy_status_summary_tb
`default_nettype wire
